// [shared/csl_pkg.sv]
// Constants, register map and field layout of the clock synthesis lock control.
// Assumes a 40 MHz system clock and a 32.768 kHz internal reference.
// What this block does
// - In low-power stop with stop source select zero, timer counts reference clock directly.
// - Outside stop, the reference clock is synchronised before it advances the timer.
// - With the loop enabled, processor bus access is held off after low-power stop until lock returns.
// - System clock may be programmed down to 131 KHz minimum.
// - No loss-of-reference detection; control bit 4 is reserved, no limp function.
// - With the loop enabled, internal reset stays asserted while the lock detector has not seen lock.
// - Slow or fast crystal, the loop compares against a 32.768 kHz reference.
// - Clock mode pin sampled at reset; zero leaves the loop disabled.
// - Lock flag stays low through re-lock; lock comes in 10 ms steps.
package csl_pkg;
  localparam int unsigned SYS_CLK_HZ    = 40_000_000;
  localparam int unsigned REF_HZ        = 32_768;
  localparam int unsigned MIN_SYS_KHZ   = 131;
  localparam int unsigned LOCK_STEP_MS  = 10;
  localparam int unsigned LOCK_WAIT_MS  = 50;
  localparam int unsigned LOCK_STEP_CYC = SYS_CLK_HZ / 1000 * LOCK_STEP_MS;
  localparam int unsigned LOCK_WAIT_STP = LOCK_WAIT_MS / LOCK_STEP_MS;
  localparam int unsigned MULT_MIN_INT  = (MIN_SYS_KHZ * 1000 + REF_HZ - 1) / REF_HZ;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;

  localparam logic [3:0] ADDR_SYNTH_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS     = 4'h1;
  localparam logic [3:0] ADDR_MASK       = 4'h2;
  localparam logic [3:0] ADDR_TMR_MOD    = 4'h3;
  localparam logic [3:0] ADDR_TMR_COUNT  = 4'h4;

  localparam int unsigned CTRL_STOP_SEL_BIT  = 0;
  localparam int unsigned CTRL_LOC_RST_BIT   = 2;
  localparam int unsigned CTRL_LOCK_BIT      = 3;
  localparam int unsigned CTRL_LIMP_BIT      = 4;
  localparam int unsigned CTRL_MULT_LSB      = 8;
  localparam int unsigned MULT_W             = 8;

  localparam int unsigned EV_W          = 4;
  localparam int unsigned EV_LOCK_GAIN  = 0;
  localparam int unsigned EV_LOCK_LOSS  = 1;
  localparam int unsigned EV_LOCK_WAIT  = 2;
  localparam int unsigned EV_TMR_EXPIRE = 3;

  localparam logic [7:0]  MULT_MIN       = 8'(MULT_MIN_INT);
  localparam logic [7:0]  MULT_RESET     = 8'h10;
  localparam logic [15:0] TMR_MOD_RESET  = 16'h0000;
  localparam logic [3:0]  MASK_RESET     = 4'h0;
endpackage

// [src/csl_sync2.sv]
// Two-stage synchroniser for a pin-level input.
// Assumes the input is asynchronous to ref_clk; flops free-run through reset.
`timescale 1ns/100ps
module csl_sync2
  import csl_pkg::*;
(
  // Clock
  input  wire logic ref_clk,
  // Data
  input  wire logic d_async,
  output logic      q_sync
);
  typedef struct packed
  {
    logic stage1;
    logic stage2;
  } csl_sync_type;

  csl_sync_type s_reg;
  csl_sync_type s_next;

  always_comb
  begin
    s_next.stage1 = d_async;
    s_next.stage2 = s_reg.stage1;
  end

  always_ff @(posedge ref_clk)
  begin
    s_reg <= s_next;
  end

  assign q_sync = s_reg.stage2;
endmodule

// [src/csl_lock_det.sv]
// Lock qualification in whole steps, with wait timeout.
// Assumes lock_raw is already synchronised to ref_clk.
`timescale 1ns/100ps
module csl_lock_det
  import csl_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = LOCK_STEP_CYC,
  parameter int unsigned WAIT_STEPS  = LOCK_WAIT_STP
)
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic reset_n,
  // Control
  input  wire logic enable,
  input  wire logic restart,
  input  wire logic lock_raw,
  // Result
  output logic      locked,
  output logic      wait_expired
);
  localparam int unsigned CW = $clog2(STEP_CYCLES);
  localparam int unsigned WW = $clog2(WAIT_STEPS + 1);
  localparam logic [CW-1:0] STEP_LAST = CW'(STEP_CYCLES - 1);
  localparam logic [WW-1:0] WAIT_LAST = WW'(WAIT_STEPS - 1);

  if (STEP_CYCLES < 2 || WAIT_STEPS < 1)
  begin : g_bad_param
    $error("csl_lock_det: step or wait count too small");
  end

  typedef struct packed
  {
    logic [CW-1:0] step_cnt;
    logic [WW-1:0] wait_cnt;
    logic          stable;
    logic          locked;
    logic          timed_out;
    logic          pulse;
  } csl_det_type;

  csl_det_type s_reg;
  csl_det_type s_next;

  always_comb
  begin
    s_next = s_reg;
    s_next.pulse = 1'b0;
    if (!enable || restart)
    begin
      s_next.step_cnt  = '0;
      s_next.wait_cnt  = '0;
      s_next.stable    = 1'b1;
      s_next.locked    = 1'b0;
      s_next.timed_out = 1'b0;
    end
    else
    begin
      if (!lock_raw)
      begin
        s_next.stable = 1'b0;
        s_next.locked = 1'b0;
      end
      if (s_reg.step_cnt == STEP_LAST)
      begin
        s_next.step_cnt = '0;
        s_next.stable   = 1'b1;
        s_next.locked   = s_reg.stable & lock_raw;
        if (s_next.locked)
        begin
          s_next.wait_cnt  = '0;
          s_next.timed_out = 1'b0;
        end
        else if (!s_reg.timed_out)
        begin
          if (s_reg.wait_cnt == WAIT_LAST)
          begin
            s_next.timed_out = 1'b1;
            s_next.pulse     = 1'b1;
          end
          else
          begin
            s_next.wait_cnt = s_reg.wait_cnt + 1'b1;
          end
        end
      end
      else
      begin
        s_next.step_cnt = s_reg.step_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      s_reg <= '{default: '0};
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign locked       = s_reg.locked;
  assign wait_expired = s_reg.pulse;
endmodule

// [src/csl_clock_synth_lock_control.sv]
// Clock synthesis control: mode capture, lock gating, stop re-lock hold, timer clocking.
// Assumes a plain register port from on-chip software and an analogue loop outside.
//
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/100ps
module csl_clock_synth_lock_control
  import csl_pkg::*;
#(
  parameter int unsigned LOCK_STEP_CYCLES = LOCK_STEP_CYC,
  parameter int unsigned LOCK_WAIT_STEPS  = LOCK_WAIT_STP
)
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  // Pins and loop
  input  wire logic              reference_clock_input,
  input  wire logic              clock_mode_select_pin,
  input  wire logic              loop_lock_raw,
  // Processor state
  input  wire logic              low_power_stop_mode,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output logic      [DATA_W-1:0] reg_rdata,
  // Loop control
  output logic                   loop_enable,
  output logic      [MULT_W-1:0] synth_multiplier,
  // System control
  output logic                   internal_reset_n,
  output logic                   cpu_bus_hold,
  output logic                   tmr_clock_direct,
  output logic                   tmr_tick,
  output logic                   irq
);
  if (LOCK_STEP_CYCLES < 2 || LOCK_WAIT_STEPS < 1)
  begin : g_bad_param
    $error("csl_clock_synth_lock_control: lock counts too small");
  end

  typedef struct packed
  {
    logic              mode_done;
    logic              loop_en;
    logic [MULT_W-1:0] mult;
    logic              stop_sel;
    logic [EV_W-1:0]   status;
    logic [EV_W-1:0]   mask;
    logic [15:0]       tmr_mod;
    logic [15:0]       tmr_cnt;
    logic              ref_prev;
    logic              stop_prev;
    logic              locked_prev;
    logic              bus_hold;
    logic              rst_n;
    logic              tick;
    logic              irq;
    logic [DATA_W-1:0] rdata;
  } csl_state_type;

  csl_state_type s_reg;
  csl_state_type s_next;

  logic ref_sync;
  logic mode_sync;
  logic lock_sync;
  logic locked;
  logic wait_expired;
  logic restart;

  // Pin synchronisers
  csl_sync2 u_sync_ref
  (
    .ref_clk (ref_clk),
    .d_async (reference_clock_input),
    .q_sync  (ref_sync)
  );

  csl_sync2 u_sync_mode
  (
    .ref_clk (ref_clk),
    .d_async (clock_mode_select_pin),
    .q_sync  (mode_sync)
  );

  csl_sync2 u_sync_lock
  (
    .ref_clk (ref_clk),
    .d_async (loop_lock_raw),
    .q_sync  (lock_sync)
  );

  // Lock qualification
  csl_lock_det
  #(
    .STEP_CYCLES (LOCK_STEP_CYCLES),
    .WAIT_STEPS  (LOCK_WAIT_STEPS)
  )
  u_lock_det
  (
    .ref_clk      (ref_clk),
    .reset_n      (reset_n),
    .enable       (s_reg.loop_en),
    .restart      (restart),
    .lock_raw     (lock_sync),
    .locked       (locked),
    .wait_expired (wait_expired)
  );

  // Register decode
  logic            wr_ctrl;
  logic            wr_status;
  logic            wr_mask;
  logic            wr_mod;
  logic [MULT_W-1:0] mult_wr;
  logic            stop_exit;
  logic            mult_change;
  logic            lock_flag;
  logic            ref_rise;
  logic            direct;
  logic            advance;
  logic [EV_W-1:0] events;
  logic [EV_W-1:0] clear;

  always_comb
  begin
    wr_ctrl   = reg_write && (reg_addr == ADDR_SYNTH_CTRL);
    wr_status = reg_write && (reg_addr == ADDR_STATUS);
    wr_mask   = reg_write && (reg_addr == ADDR_MASK);
    wr_mod    = reg_write && (reg_addr == ADDR_TMR_MOD);
    mult_wr   = reg_wdata[CTRL_MULT_LSB +: MULT_W];
    if (mult_wr < MULT_MIN)
    begin
      mult_wr = MULT_MIN;
    end
  end

  // Re-lock after stop exit or a new multiplier
  always_comb
  begin
    stop_exit   = s_reg.stop_prev && !low_power_stop_mode;
    mult_change = wr_ctrl && (mult_wr != s_reg.mult);
    restart     = s_reg.loop_en && (stop_exit || mult_change);
    lock_flag   = s_reg.loop_en && locked;
  end

  // Timer clock source
  always_comb
  begin
    ref_rise = ref_sync && !s_reg.ref_prev;
    direct   = low_power_stop_mode && !s_reg.stop_sel;
    if (direct)
    begin
      advance = 1'b1;
    end
    else if (!low_power_stop_mode)
    begin
      advance = ref_rise;
    end
    else
    begin
      advance = 1'b0;
    end
  end

  // Events and clears
  always_comb
  begin
    events = '0;
    events[EV_LOCK_GAIN] = lock_flag && !s_reg.locked_prev;
    events[EV_LOCK_LOSS] = !lock_flag && s_reg.locked_prev;
    events[EV_LOCK_WAIT] = wait_expired;
    events[EV_TMR_EXPIRE] = advance && (s_reg.tmr_mod != 16'h0000)
                            && (s_reg.tmr_cnt == 16'h0001);
    clear = wr_status ? reg_wdata[EV_W-1:0] : '0;
  end

  // Next state
  always_comb
  begin
    s_next = s_reg;
    s_next.ref_prev    = ref_sync;
    s_next.stop_prev   = low_power_stop_mode;
    s_next.locked_prev = lock_flag;
    s_next.tick        = advance;

    // Mode pin caught on the first edge after reset release
    if (!s_reg.mode_done)
    begin
      s_next.mode_done = 1'b1;
      s_next.loop_en   = mode_sync;
    end

    // Control register
    if (wr_ctrl)
    begin
      s_next.stop_sel = reg_wdata[CTRL_STOP_SEL_BIT];
      s_next.mult     = mult_wr;
    end

    // Timer counter
    if (wr_mod)
    begin
      s_next.tmr_mod = reg_wdata;
      s_next.tmr_cnt = reg_wdata;
    end
    else if (advance && (s_reg.tmr_mod != 16'h0000))
    begin
      if (s_reg.tmr_cnt <= 16'h0001)
      begin
        s_next.tmr_cnt = s_reg.tmr_mod;
      end
      else
      begin
        s_next.tmr_cnt = s_reg.tmr_cnt - 16'h0001;
      end
    end

    // Sticky status, set wins over clear
    s_next.status = (s_reg.status & ~clear) | events;
    if (wr_mask)
    begin
      s_next.mask = reg_wdata[EV_W-1:0];
    end
    s_next.irq = |(s_next.status & s_next.mask);

    // Processor hold after stop
    if (restart && stop_exit)
    begin
      s_next.bus_hold = 1'b1;
    end
    else if (locked || !s_reg.loop_en)
    begin
      s_next.bus_hold = 1'b0;
    end

    // Internal reset until the loop first locks; released at once with the loop disabled
    s_next.rst_n = s_reg.rst_n || (s_reg.mode_done && !(s_reg.loop_en && !locked));

    // Read data, present only the cycle after the strobe
    s_next.rdata = '0;
    if (reg_read)
    begin
      unique case (reg_addr)
        ADDR_SYNTH_CTRL:
        begin
          s_next.rdata[CTRL_MULT_LSB +: MULT_W] = s_reg.mult;
          s_next.rdata[CTRL_STOP_SEL_BIT]       = s_reg.stop_sel;
          s_next.rdata[CTRL_LOCK_BIT]           = lock_flag;
          s_next.rdata[CTRL_LIMP_BIT]           = 1'b0;
          s_next.rdata[CTRL_LOC_RST_BIT]        = 1'b0;
        end
        ADDR_STATUS:
        begin
          s_next.rdata[EV_W-1:0] = s_reg.status;
        end
        ADDR_MASK:
        begin
          s_next.rdata[EV_W-1:0] = s_reg.mask;
        end
        ADDR_TMR_MOD:
        begin
          s_next.rdata = s_reg.tmr_mod;
        end
        ADDR_TMR_COUNT:
        begin
          s_next.rdata = s_reg.tmr_cnt;
        end
        default:
        begin
          s_next.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      s_reg.mode_done   <= 1'b0;
      s_reg.loop_en     <= 1'b0;
      s_reg.mult        <= MULT_RESET;
      s_reg.stop_sel    <= 1'b0;
      s_reg.status      <= '0;
      s_reg.mask        <= MASK_RESET;
      s_reg.tmr_mod     <= TMR_MOD_RESET;
      s_reg.tmr_cnt     <= TMR_MOD_RESET;
      s_reg.ref_prev    <= 1'b1;
      s_reg.stop_prev   <= 1'b0;
      s_reg.locked_prev <= 1'b0;
      s_reg.bus_hold    <= 1'b0;
      s_reg.rst_n       <= 1'b0;
      s_reg.tick        <= 1'b0;
      s_reg.irq         <= 1'b0;
      s_reg.rdata       <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // Outputs
  assign reg_rdata        = s_reg.rdata;
  assign loop_enable      = s_reg.loop_en;
  assign synth_multiplier = s_reg.mult;
  assign internal_reset_n = s_reg.rst_n;
  assign cpu_bus_hold     = s_reg.bus_hold;
  assign tmr_clock_direct = low_power_stop_mode && !s_reg.stop_sel;
  assign tmr_tick         = s_reg.tick;
  assign irq              = s_reg.irq;
endmodule

// [testbench/csl_props.sv]
// Port-level property checker for the clock synthesis lock control.
// Assumes it is bound into the top module; one clock domain.
`timescale 1ns/100ps
module csl_props
  import csl_pkg::*;
(
  // Clock and reset
  input wire logic              ref_clk,
  input wire logic              reset_n,
  // Inputs watched
  input wire logic              loop_lock_raw,
  input wire logic              reference_clock_input,
  input wire logic              low_power_stop_mode,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic              reg_read,
  // Outputs watched
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic              loop_enable,
  input wire logic              internal_reset_n,
  input wire logic              cpu_bus_hold,
  input wire logic              tmr_clock_direct,
  input wire logic              tmr_tick
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  logic [1:0] up_reg;
  logic [1:0] up_next;
  always_comb up_next = (up_reg == 2'h3) ? up_reg : up_reg + 2'h1;
  always_ff @(posedge ref_clk)
  begin
    up_reg <= reset_n ? up_next : 2'h0;
  end

  sequence stop_exit;
    loop_enable && $fell(low_power_stop_mode);
  endsequence
  sequence ctrl_read;
    reg_read && reg_addr == ADDR_SYNTH_CTRL;
  endsequence

  chk_direct_in_stop: assert property (tmr_clock_direct |-> low_power_stop_mode)
    else $error("direct timer clock outside stop");
  chk_tick_synced: assert property (
    (!low_power_stop_mode && !reference_clock_input) [*6] |=> !tmr_tick)
    else $error("timer advanced without a reference edge");
  chk_hold_on_exit: assert property (stop_exit |=> cpu_bus_hold)
    else $error("no bus hold after stop exit");
  chk_hold_till_lock: assert property (
    (!loop_lock_raw) [*8] ##0 cpu_bus_hold |=> cpu_bus_hold)
    else $error("bus hold dropped without lock");
  chk_reserved_bits: assert property (
    ctrl_read |=> !reg_rdata[CTRL_LIMP_BIT] && !reg_rdata[CTRL_LOC_RST_BIT])
    else $error("reserved control bit reads one");
  chk_reset_needs_lock: assert property (
    $rose(internal_reset_n) && loop_enable |-> $past(loop_lock_raw, 4))
    else $error("internal reset released before lock");
  chk_reset_loop_off: assert property (up_reg == 2'h3 && !loop_enable |-> internal_reset_n)
    else $error("internal reset held with loop disabled");
  chk_mode_kept: assert property (up_reg[1] |-> $stable(loop_enable))
    else $error("loop enable changed after reset");
  chk_lock_flag_low: assert property (
    (!loop_lock_raw) [*6] ##0 ctrl_read |=> !reg_rdata[CTRL_LOCK_BIT])
    else $error("lock flag set while unlocked");
endmodule

bind csl_clock_synth_lock_control csl_props u_props (.ref_clk, .reset_n, .loop_lock_raw,
  .reference_clock_input, .low_power_stop_mode, .reg_addr, .reg_read, .reg_rdata,
  .loop_enable, .internal_reset_n, .cpu_bus_hold, .tmr_clock_direct, .tmr_tick);

// [testbench/csl_ref_model.sv]
// Reference clock source and analogue loop lock model.
// Assumes the bench raises relock while the loop is meant to be out of lock.
`timescale 1ns/100ps
module csl_ref_model
#(
  parameter int HALF_NS  = 163,
  parameter int LOCK_CYC = 60
)
(
  // Clock and loop state
  input  wire logic ref_clk,
  input  wire logic loop_enable,
  input  wire logic relock,
  // Pins
  output logic      reference_clock_input,
  output logic      loop_lock_raw
);
  int lock_cnt = 0;
  // Free-running crystal, unrelated in phase to ref_clk
  initial
  begin
    reference_clock_input = 1'b0;
    forever #(HALF_NS) reference_clock_input = !reference_clock_input;
  end
  // Lock after a settling time, lost at once on relock
  always @(posedge ref_clk)
  begin
    if (!loop_enable || relock)
      lock_cnt <= 0;
    else if (lock_cnt < LOCK_CYC)
      lock_cnt <= lock_cnt + 1;
  end
  assign loop_lock_raw = (lock_cnt == LOCK_CYC);
endmodule

// [testbench/csl_clock_synth_lock_control_test.sv]
// Self-checking bench for the clock synthesis lock control.
// Assumes the reference model drives the reference pin and raw lock.
`timescale 1ns/100ps
module csl_clock_synth_lock_control_test import csl_pkg::*;;
  logic              ref_clk = 1'b0;
  logic              reset_n = 1'b0;
  logic              mode_pin = 1'b1;
  logic              stop = 1'b0;
  logic              relock = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic              reg_write = 1'b0;
  logic              reg_read = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic [MULT_W-1:0] synth_multiplier;
  logic              ref_in, lock_raw, loop_enable, internal_reset_n;
  logic              cpu_bus_hold, tmr_clock_direct, tmr_tick, irq;
  int                n_mismatch = 0;
  int                samples_checked = 0;
  int                t, r;

  always #12.5 ref_clk = ~ref_clk;

  csl_clock_synth_lock_control #(.LOCK_STEP_CYCLES(20), .LOCK_WAIT_STEPS(5)) DUT (
    .ref_clk(ref_clk), .reset_n(reset_n), .reference_clock_input(ref_in),
    .clock_mode_select_pin(mode_pin), .loop_lock_raw(lock_raw),
    .low_power_stop_mode(stop), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .loop_enable(loop_enable), .synth_multiplier(synth_multiplier),
    .internal_reset_n(internal_reset_n), .cpu_bus_hold(cpu_bus_hold),
    .tmr_clock_direct(tmr_clock_direct), .tmr_tick(tmr_tick), .irq(irq));

  csl_ref_model u_ref (.ref_clk(ref_clk), .loop_enable(loop_enable), .relock(relock),
    .reference_clock_input(ref_in), .loop_lock_raw(lock_raw));

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic do_reset(input logic m);
    reset_n <= 1'b0;
    mode_pin <= m;
    cyc(3);
    reset_n <= 1'b1;
    cyc(1);
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    @(negedge ref_clk);
    check(reg_rdata & m, e);
    @(posedge ref_clk);
  endtask

  task automatic wait_for(input bit on_hold, input logic v);
    int i;
    i = 0;
    while ((on_hold ? cpu_bus_hold : internal_reset_n) !== v && i < 400)
    begin
      @(negedge ref_clk);
      i++;
    end
    @(posedge ref_clk);
    check(16'(i < 400), 16'h1);
    if (i >= 400)
      results();
  endtask

  task automatic count(input int n, output int tk, output int rs);
    logic p;
    tk = 0;
    rs = 0;
    p = ref_in;
    repeat (n)
    begin
      @(negedge ref_clk);
      tk += int'(tmr_tick);
      rs += int'(ref_in && !p);
      p = ref_in;
    end
    @(posedge ref_clk);
  endtask

  task automatic t_powerup();
    relock <= 1'b1;
    do_reset(1'b1);
    cyc(80);
    rdchk(ADDR_STATUS, 16'h0004, 16'h0000);
    cyc(117);
    check(16'(internal_reset_n), 16'h0);
    check(16'(synth_multiplier), 16'(MULT_RESET));
    rdchk(ADDR_SYNTH_CTRL, 16'h0008, 16'h0000);
    rdchk(ADDR_STATUS, 16'h0004, 16'h0004);
    relock <= 1'b0;
    wait_for(1'b0, 1'b1);
    rdchk(ADDR_SYNTH_CTRL, 16'h0008, 16'h0008);
    wr(ADDR_MASK, 16'h0001);
    cyc(1);
    @(negedge ref_clk);
    check(16'(irq), 16'h1);
    @(posedge ref_clk);
    wr(ADDR_STATUS, 16'h0007);
    cyc(2);
    check(16'(irq), 16'h0);
    $display("powerup done");
  endtask

  task automatic t_ctrl();
    wr(ADDR_SYNTH_CTRL, 16'h0211);
    rdchk(ADDR_SYNTH_CTRL, 16'hfff7, {MULT_MIN, 8'h01});
    check(16'(synth_multiplier), 16'(MULT_MIN));
    wr(4'hf, 16'hffff);
    rdchk(4'hf, 16'hffff, 16'h0000);
    $display("ctrl done");
  endtask

  task automatic t_stop();
    wr(ADDR_SYNTH_CTRL, 16'h1000);
    cyc(1);
    wr(ADDR_TMR_MOD, 16'h0005);
    stop <= 1'b1;
    count(20, t, r);
    check(16'(tmr_clock_direct), 16'h1);
    check(16'(t >= 18), 16'h1);
    stop <= 1'b0;
    relock <= 1'b1;
    cyc(2);
    relock <= 1'b0;
    check(16'(cpu_bus_hold), 16'h1);
    check(16'(internal_reset_n), 16'h1);
    rdchk(ADDR_SYNTH_CTRL, 16'h0008, 16'h0000);
    wait_for(1'b1, 1'b0);
    rdchk(ADDR_SYNTH_CTRL, 16'h0008, 16'h0008);
    $display("stop done");
  endtask

  task automatic t_timer();
    count(260, t, r);
    check(16'((t + 1 >= r) && (t <= r + 1)), 16'h1);
    rdchk(ADDR_STATUS, 16'h0008, 16'h0008);
    wr(ADDR_SYNTH_CTRL, 16'h1001);
    stop <= 1'b1;
    cyc(1);
    count(40, t, r);
    check(16'(t), 16'h0000);
    check(16'(tmr_clock_direct), 16'h0);
    stop <= 1'b0;
    $display("timer done");
  endtask

  task automatic t_mode_off();
    do_reset(1'b0);
    cyc(3);
    check(16'(loop_enable), 16'h0);
    check(16'(internal_reset_n), 16'h1);
    stop <= 1'b1;
    cyc(4);
    stop <= 1'b0;
    cyc(3);
    check(16'(cpu_bus_hold), 16'h0);
    rdchk(ADDR_SYNTH_CTRL, 16'h0008, 16'h0000);
    $display("mode_off done");
  endtask

  initial
  begin
    t_powerup();
    t_ctrl();
    t_stop();
    t_timer();
    t_mode_off();
    results();
  end
endmodule
